// File: src/pcc_capture_compare.sv
`timescale 1ns/10ps
module pcc_capture_compare (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_n,
  input  wire pcc_pkg::pcc_bus_req_s i_bus,
  output logic [pcc_pkg::DATA_W-1:0] o_readdata,
  output logic                      o_waitrequest,
  input  wire logic                 i_module_io_pin,
  output logic                      o_irq,
  output logic [15:0]               o_count
);
  import pcc_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    pcc_mode_s    mode;
    logic [7:0]   cmp_low;
    logic [7:0]   cmp_high;
    logic [15:0]  count;
    logic         run;
    logic         event_flag;
    logic         pin_sync1;
    logic         pin_sync2;
    logic         pin_prev;
    logic         acked;
    logic [DATA_W-1:0] rdata;
    logic         irq;
  } pcc_state_s;

  pcc_state_s state;
  pcc_state_s next_state;

  logic capture_mode;
  logic compare_mode;
  logic rise_seen;
  logic fall_seen;
  logic capture_hit;
  logic match_hit;
  logic access;
  logic wr_go;
  logic rd_go;
  logic [15:0] next_count_val;

  // ---------------------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------------------
  always_comb begin
    capture_mode   = state.mode.fall_en | state.mode.rise_en;
    compare_mode   = state.mode.cmp_en & state.mode.match_en;
    rise_seen      = state.pin_sync2 & ~state.pin_prev;
    fall_seen      = ~state.pin_sync2 & state.pin_prev;
    capture_hit    = capture_mode & ((rise_seen & state.mode.rise_en) |
                                     (fall_seen & state.mode.fall_en));
    match_hit      = compare_mode & state.run &
                     (state.count == {state.cmp_high, state.cmp_low});
    next_count_val = state.run ? state.count + 16'h0001 : state.count;
    access         = (i_bus.read | i_bus.write) & ~state.acked;
    // A write lands on the edge at which the master sees waitrequest low.
    wr_go          = i_bus.write & state.acked;
    rd_go          = i_bus.read & ~i_bus.write & ~state.acked;
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_state.pin_sync1 = i_module_io_pin;
    next_state.pin_sync2 = state.pin_sync1;
    next_state.pin_prev  = state.pin_sync2;
    next_state.count     = next_count_val;
    next_state.acked     = access;
    next_state.rdata     = '0;

    if (rd_go) begin
      unique case (i_bus.address)
        ADDR_MODE:     next_state.rdata = {25'h0000000, state.mode};
        ADDR_CMP_LOW:  next_state.rdata = {24'h000000, state.cmp_low};
        ADDR_CMP_HIGH: next_state.rdata = {24'h000000, state.cmp_high};
        ADDR_CTRL: begin
          next_state.rdata[CTRL_EVENT_BIT] = state.event_flag;
          next_state.rdata[CTRL_RUN_BIT]   = state.run;
        end
        default:       next_state.rdata = '0;
      endcase
    end

    if (wr_go) begin
      unique case (i_bus.address)
        ADDR_MODE: next_state.mode = pcc_mode_s'(i_bus.writedata[6:0]);
        ADDR_CMP_LOW: begin
          next_state.cmp_low     = i_bus.writedata[7:0];
          next_state.mode.cmp_en = 1'b0;
        end
        ADDR_CMP_HIGH: begin
          next_state.cmp_high    = i_bus.writedata[7:0];
          next_state.mode.cmp_en = 1'b1;
        end
        ADDR_CTRL: begin
          next_state.run = i_bus.writedata[CTRL_RUN_BIT];
          if (i_bus.writedata[CTRL_EVENT_BIT]) begin
            next_state.event_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Capture overrides a same-cycle bus write to the pair.
    if (capture_hit) begin
      next_state.cmp_high = state.count[15:8];
      next_state.cmp_low  = state.count[7:0];
    end

    // Hardware set wins over a same-cycle clear.
    if (capture_hit | match_hit) begin
      next_state.event_flag = 1'b1;
    end

    next_state.irq = next_state.event_flag & next_state.mode.irq_en;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state       <= '0;
      state.mode  <= pcc_mode_s'(MODE_RESET[6:0]);
      state.cmp_low  <= CMP_RESET;
      state.cmp_high <= CMP_RESET;
      state.count <= COUNT_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    o_readdata    = state.rdata;
    o_waitrequest = ~state.acked;
    o_irq         = state.irq;
    o_count       = state.count;
  end

endmodule // pcc_capture_compare

// File: src/pcc_pkg.sv
package pcc_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE      = 4'h0;
  localparam logic [3:0] ADDR_CMP_LOW   = 4'h4;
  localparam logic [3:0] ADDR_CMP_HIGH  = 4'h8;
  localparam logic [3:0] ADDR_CTRL      = 4'hC;

  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 32;

  // ---------------------------------------------------------------------------
  // Mode register field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned MODE_IRQ_EN_BIT   = 0;
  localparam int unsigned MODE_MATCH_EN_BIT = 3;
  localparam int unsigned MODE_FALL_EN_BIT  = 4;
  localparam int unsigned MODE_RISE_EN_BIT  = 5;
  localparam int unsigned MODE_CMP_EN_BIT   = 6;

  // ---------------------------------------------------------------------------
  // Counter control register field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_EVENT_BIT    = 0;
  localparam int unsigned CTRL_RUN_BIT      = 6;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  MODE_RESET        = 8'h00;
  localparam logic [7:0]  CMP_RESET         = 8'h00;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;

  // Mode register contents.
  typedef struct packed {
    logic       cmp_en;
    logic       rise_en;
    logic       fall_en;
    logic       match_en;
    logic [1:0] spare;
    logic       irq_en;
  } pcc_mode_s;

  // Avalon-MM slave request.
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
  } pcc_bus_req_s;

  // Avalon-MM slave answer.
  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
  } pcc_bus_rsp_s;

endpackage

// File: test/pcc_cc_assertions.sv
`timescale 1ns/10ps
module pcc_cc_assertions (
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst_n,
  input wire pcc_pkg::pcc_bus_req_s i_bus,
  input wire logic [31:0]           o_readdata,
  input wire logic                  o_waitrequest,
  input wire logic                  i_module_io_pin,
  input wire logic                  o_irq,
  input wire logic [15:0]           o_count
);
  import pcc_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_ack; (i_bus.read || i_bus.write) && o_waitrequest |=> !o_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_one; !o_waitrequest |=> o_waitrequest; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_idle; !(i_bus.read || i_bus.write) |=> o_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_rdz; o_waitrequest |-> o_readdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
  property p_unmap; i_bus.read && o_waitrequest && i_bus.address[1:0] != 2'h0 |=> o_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_upper; o_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_step; 16'(o_count - $past(o_count)) <= 16'h1; endproperty
  a_step: assert property (p_step) else $error("counter jumped");
  property p_fall; $fell(o_irq) |-> $past(i_bus.write); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped without write");
endmodule // pcc_cc_assertions
bind pcc_capture_compare pcc_cc_assertions u_chk (.i_ref_clk, .i_rst_n, .i_bus, .o_readdata,
  .o_waitrequest, .i_module_io_pin, .o_irq, .o_count);

// File: test/pcc_pin_source.sv
`timescale 1ns/10ps
module pcc_pin_source (
  input  wire logic i_ref_clk,
  input  wire logic i_level,
  input  wire logic i_slow,
  output logic      o_pin
);
  logic held;
  // Slow mode lets the pin follow one clock later than prompt mode.
  always_ff @(posedge i_ref_clk) begin
    held  <= i_level;
    o_pin <= i_slow ? held : i_level;
  end
endmodule // pcc_pin_source

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
  import pcc_pkg::*;
  logic         i_ref_clk = 0, i_rst_n = 0, lvl = 0, slow = 0, pin, wr, irq;
  logic [31:0]  rdata, q;
  logic [15:0]  cnt, v;
  pcc_bus_req_s req = '0;
  int           bad_count = 0, checks = 0, cyc = 0;
  pcc_capture_compare u_dut (.i_ref_clk, .i_rst_n, .i_bus(req), .o_readdata(rdata),
    .o_waitrequest(wr), .i_module_io_pin(pin), .o_irq(irq), .o_count(cnt));
  pcc_pin_source u_src (.i_ref_clk, .i_level(lvl), .i_slow(slow), .o_pin(pin));
  initial forever #4 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    if (++cyc == 20000) bad_count++;
    if (cyc == 20000) give_verdict();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    req <= '{address: a, read: !w, write: w, writedata: d};
    do @(posedge i_ref_clk); while (wr !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wait_irq(input int lim);
    for (int n = 0; n < lim && irq !== 1'b1; n++) @(posedge i_ref_clk);
    chk(irq, 1'b1);
  endtask
  task automatic t_reset;
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_CMP_HIGH, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    rd(4'h2, 32'h0);
  endtask
  task automatic t_capture;
    bus(1'b1, ADDR_CTRL, 32'h40);
    repeat (20) @(posedge i_ref_clk);
    bus(1'b1, ADDR_CTRL, 32'h00);
    @(posedge i_ref_clk);
    v = cnt;
    bus(1'b1, ADDR_MODE, 32'h21);
    lvl <= 1'b1;
    wait_irq(20);
    rd(ADDR_CTRL, 32'h01);
    rd(ADDR_CMP_LOW, {24'h0, v[7:0]});
    rd(ADDR_CMP_HIGH, {24'h0, v[15:8]});
    bus(1'b1, ADDR_CTRL, 32'h01);
    lvl <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    rd(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_fall;
    bus(1'b1, ADDR_MODE, 32'h10);
    slow <= 1'b1;
    lvl <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    rd(ADDR_CTRL, 32'h0);
    lvl <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    rd(ADDR_CTRL, 32'h01);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h01);
    rd(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_compare;
    bus(1'b1, ADDR_MODE, 32'h00);
    v = cnt + 16'h0101;
    bus(1'b1, ADDR_CMP_LOW, {24'h0, v[7:0]});
    bus(1'b1, ADDR_CMP_HIGH, {24'h0, v[15:8]});
    rd(ADDR_MODE, 32'h40);
    bus(1'b1, ADDR_CMP_LOW, {24'h0, v[7:0]});
    rd(ADDR_MODE, 32'h00);
    bus(1'b1, ADDR_MODE, 32'h49);
    rd(ADDR_MODE, 32'h49);
    bus(1'b1, ADDR_CTRL, 32'h40);
    wait_irq(400);
    chk(16'(cnt - v) <= 16'h3, 1'b1);
    rd(ADDR_CTRL, 32'h41);
  endtask
  task automatic give_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_capture;
    t_fall;
    t_compare;
    give_verdict();
  end
endmodule // tb
